/* File: pkg/irq_ctl_consts.vh */
/*
  Constants of the interrupt controller with halt wake logic: register
  offsets, field positions, reset values, vectors and timing counts.
  Assumes it is included by bare name from design files under rtl/.
*/
`ifndef IRQ_CTL_CONSTS_VH
`define IRQ_CTL_CONSTS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define A_SWPRIO0   4'h0
`define A_SWPRIO1   4'h1
`define A_SWPRIO2   4'h2
`define A_SWPRIO3   4'h3
`define A_EXT_SENSE 4'h4
`define A_EXT_SEL   4'h5
`define A_CLK_CTL   4'h6
`define A_STATUS    4'h7
`define A_PEND_LO   4'h8
`define A_PEND_HI   4'h9

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define CTL_RTC_IE     0
`define CTL_AWU_EN     1
`define CTL_TLI_RISE   2
`define SWPRIO_RST     8'hFF
`define EXT_SENSE_RST  8'h00
`define EXT_SEL_RST    8'hFF
`define CLK_CTL_RST    8'h00

// sensitivity codes of one external line
`define SENSE_FALL_LOW 2'h0
`define SENSE_RISE     2'h1
`define SENSE_FALL     2'h2
`define SENSE_BOTH     2'h3

// ----------------------------------------------------------------------
// core interface
// ----------------------------------------------------------------------
`define HALT_OPCODE    8'h8E
`define CC_LEVEL3      2'h3
`define CC_ACTIVE_HALT 2'h2
`define VEC_RESET      16'hFFFE
`define VEC_TRAP       16'hFFFC
`define VEC_SRC0       16'hFFFA
`define STACK_IRQ      3'h5
`define STACK_NONE     3'h0

// ----------------------------------------------------------------------
// source masks (bit n = source n)
// ----------------------------------------------------------------------
`define SRC_PERIPH     14'h3F02
`define SRC_EDGE_LATCH 14'h003D
`define WAKE_HALT      14'h213D
`define WAKE_ACT_HALT  14'h213F

// ----------------------------------------------------------------------
// timing counts in cpu cycles
// ----------------------------------------------------------------------
`define RST_DLY_LONG   13'h1000
`define RST_DLY_SHORT  13'h0100

`endif

/* File: rtl/pin_filter3.v */
/*
  Three-stage input filter for pins from outside the clock domain.
  Assumes clk is the cpu clock; q changes only when stages two and
  three agree.
*/
`timescale 1ns/1ns
`default_nettype none

module pin_filter3 #(
  parameter         W       = 1,
  parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
  input  wire         clk,
  input  wire         ce,
  input  wire         srst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;

  always @(posedge clk) begin
    if (srst) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      q  <= RST_VAL;
    end else if (ce) begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      // s1 feeds nothing but s2, so metastability stays contained
      q  <= (s2 & ~(s2 ^ s3)) | (q & (s2 ^ s3));
    end
  end

endmodule // pin_filter3

`default_nettype wire

/* File: rtl/irq_controller_halt_wake.v */
/*
  Interrupt controller of an 8-bit core with HALT / ACTIVE HALT wake.
  Assumes the core pulses insn_boundary between instructions, reports
  executed opcodes, trap and condition-register pops, and pushes the
  context itself when irq_take shows push_bytes.
*/
`timescale 1ns/1ns
`default_nettype none
`include "irq_ctl_consts.vh"

module irq_controller_halt_wake #(
  parameter [12:0] LONG_DLY  = `RST_DLY_LONG,
  parameter [12:0] SHORT_DLY = `RST_DLY_SHORT
) (
  input  wire        clk,
  input  wire        ce,
  input  wire        srst,
  input  wire [3:0]  addr,
  input  wire [7:0]  wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [7:0]  rdata,
  input  wire        top_level_pin_irq,
  input  wire [7:0]  ext_pins,
  input  wire [13:0] periph_flag,
  input  wire [13:0] periph_en,
  input  wire [13:0] periph_clr,
  input  wire        insn_boundary,
  input  wire        exec_strobe,
  input  wire [7:0]  exec_opcode,
  input  wire        trap_exec,
  input  wire        cc_pop,
  input  wire [1:0]  pop_mask,
  input  wire        long_delay_opt,
  output reg         irq_take,
  output reg  [15:0] irq_vector,
  output reg  [2:0]  push_bytes,
  output reg         mask_level_high,
  output reg         mask_level_low,
  output reg         cpu_hold,
  output reg         cpu_halted,
  output reg         active_halt,
  output reg         periph_clk_en,
  output reg         osc_run,
  output reg         time_base_run,
  output reg         wdg_reset_inhibit
);

  // ----------------------------------------------------------------------
  // states and helpers
  // ----------------------------------------------------------------------
  localparam [3:0] ST_RST_DLY = 4'h1;
  localparam [3:0] ST_RUN     = 4'h2;
  localparam [3:0] ST_HALT    = 4'h4;
  localparam [3:0] ST_AHALT   = 4'h8;

  localparam [1:0] TK_NONE  = 2'h0;
  localparam [1:0] TK_RESET = 2'h1;
  localparam [1:0] TK_TRAP  = 2'h2;
  localparam [1:0] TK_SRC   = 2'h3;

  // mask bit pair to numeric level: 10b=0, 01b=1, 00b=2, 11b=3
  function [1:0] lvl;
    input [1:0] cc;
    begin
      case (cc)
        2'h2:    lvl = 2'h0;
        2'h1:    lvl = 2'h1;
        2'h0:    lvl = 2'h2;
        default: lvl = 2'h3;
      endcase
    end
  endfunction

  function [15:0] src_vec;
    input [3:0] n;
    begin
      src_vec = `VEC_SRC0 - {11'h000, n, 1'b0};
    end
  endfunction

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  reg  [7:0]  swp0;
  reg  [7:0]  swp1;
  reg  [7:0]  swp2;
  reg  [7:0]  swp3;
  reg  [7:0]  ext_irq_sense_ctl;
  reg  [7:0]  ext_sel;
  reg  [7:0]  clk_ctl;
  wire [31:0] sw_priority_regs = {swp3, swp2, swp1, swp0};
  wire        rtc_irq_enable   = clk_ctl[`CTL_RTC_IE];
  wire        auto_wake_enable = clk_ctl[`CTL_AWU_EN];

  always @(posedge clk) begin
    if (srst) begin
      swp0              <= `SWPRIO_RST;
      swp1              <= `SWPRIO_RST;
      swp2              <= `SWPRIO_RST;
      swp3              <= `SWPRIO_RST;
      ext_irq_sense_ctl <= `EXT_SENSE_RST;
      ext_sel           <= `EXT_SEL_RST;
      clk_ctl           <= `CLK_CTL_RST;
    end else if (ce && wr) begin
      case (addr)
        `A_SWPRIO0:   swp0 <= wdata;
        `A_SWPRIO1:   swp1 <= wdata;
        `A_SWPRIO2:   swp2 <= wdata;
        `A_SWPRIO3:   swp3 <= wdata;
        `A_EXT_SENSE: ext_irq_sense_ctl <= wdata;
        `A_EXT_SEL:   ext_sel <= wdata;
        `A_CLK_CTL:   clk_ctl <= {5'h00, wdata[2:0]};
        default:      ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // pin inputs and edge detection
  // ----------------------------------------------------------------------
  wire [8:0] pin_q;
  reg  [3:0] line_prev;
  reg        tli_prev;
  wire [3:0] line_now;
  wire [3:0] line_edge;
  wire [3:0] line_low;

  pin_filter3 #(
    .W       (9),
    .RST_VAL (9'h1FF)
  ) u_pins (
    .clk  (clk),
    .ce   (ce),
    .srst (srst),
    .d    ({top_level_pin_irq, ext_pins}),
    .q    (pin_q)
  );

  wire tli_now  = pin_q[8];
  wire tli_edge = clk_ctl[`CTL_TLI_RISE] ? (tli_now & ~tli_prev)
                                         : (~tli_now & tli_prev);

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_line
      wire [1:0] sense = ext_irq_sense_ctl[2*g +: 2];
      wire       rise  = line_now[g] & ~line_prev[g];
      wire       fall  = ~line_now[g] & line_prev[g];
      // pins idle high: the line drops when any selected pin drops
      assign line_now[g]  = &(pin_q[2*g +: 2] | ~ext_sel[2*g +: 2]);
      assign line_edge[g] = (sense == `SENSE_RISE) ? rise :
                            (sense == `SENSE_BOTH) ? (rise | fall) :
                            fall;
      assign line_low[g]  = (sense == `SENSE_FALL_LOW) & ~line_now[g];
    end
  endgenerate

  always @(posedge clk) begin
    if (srst) begin
      line_prev <= 4'hF;
      tli_prev  <= 1'b1;
    end else if (ce) begin
      line_prev <= line_now;
      tli_prev  <= tli_now;
    end
  end

  // ----------------------------------------------------------------------
  // pending requests
  // ----------------------------------------------------------------------
  reg  [13:0] pend;
  reg         trap_pend;
  reg         in_trap;
  reg         tli_active;
  reg  [3:0]  state;
  reg  [12:0] dly_cnt;
  reg  [1:0]  mask;

  wire [13:0] set_now = periph_flag & periph_en & `SRC_PERIPH;
  wire [13:0] edge_set = {8'h00, line_edge, 1'b0, tli_edge};
  wire [13:0] level_req = {8'h00, line_low, 2'b00};
  wire [13:0] req = pend | level_req;

  // ----------------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------------
  wire [1:0] eff_mask = cc_pop ? pop_mask : mask;
  wire [1:0] cur_lvl  = lvl(eff_mask);
  reg        best_found;
  reg  [3:0] best_idx;
  reg  [1:0] best_lvl;
  reg  [1:0] best_cc;
  reg  [1:0] p_cc;
  integer    i;

  always @* begin
    best_found = 1'b0;
    best_idx   = 4'h0;
    best_lvl   = 2'h0;
    best_cc    = 2'h0;
    p_cc       = 2'h0;
    // walking down with >= lets the lower source number win ties
    for (i = 13; i >= 1; i = i - 1) begin
      p_cc = sw_priority_regs[2*i +: 2];
      if (req[i] && (lvl(p_cc) > cur_lvl) &&
          (!best_found || lvl(p_cc) >= best_lvl)) begin
        best_found = 1'b1;
        best_idx   = i[3:0];
        best_lvl   = lvl(p_cc);
        best_cc    = p_cc;
      end
    end
  end

  wire tli_ok = req[0] && ((cur_lvl != 2'h3) || in_trap);
  wire is_halt = exec_strobe && (exec_opcode == `HALT_OPCODE);
  wire ahalt_sel = rtc_irq_enable && !auto_wake_enable;
  wire [13:0] wake_set = (state == ST_AHALT) ? `WAKE_ACT_HALT
                                             : `WAKE_HALT;
  wire wake_now = |(req & wake_set);
  wire [12:0] dly_last = (long_delay_opt ? LONG_DLY : SHORT_DLY) - 13'h0001;

  // ----------------------------------------------------------------------
  // next state and entry decision
  // ----------------------------------------------------------------------
  reg [3:0]  next_state;
  reg [1:0]  next_kind;
  reg [15:0] next_vec;
  reg [1:0]  next_mask;
  reg [13:0] next_clr;

  always @* begin
    next_state = state;
    next_kind  = TK_NONE;
    next_vec   = irq_vector;
    next_mask  = eff_mask;
    next_clr   = 14'h0000;
    case (state)
      ST_RST_DLY: begin
        if (dly_cnt == dly_last) begin
          next_state = ST_RUN;
          next_kind  = TK_RESET;
          next_vec   = `VEC_RESET;
          next_mask  = `CC_LEVEL3;
        end
      end
      ST_RUN: begin
        if (is_halt) begin
          next_mask  = `CC_ACTIVE_HALT;
          next_state = ahalt_sel ? ST_AHALT : ST_HALT;
        end else if (insn_boundary) begin
          if (trap_pend) begin
            next_kind = TK_TRAP;
            next_vec  = `VEC_TRAP;
            next_mask = `CC_LEVEL3;
          end else if (tli_ok) begin
            next_kind = TK_SRC;
            next_vec  = src_vec(4'h0);
            next_mask = `CC_LEVEL3;
            next_clr  = 14'h0001;
          end else if (best_found) begin
            next_kind = TK_SRC;
            next_vec  = src_vec(best_idx);
            next_mask = best_cc;
            next_clr  = (14'h0001 << best_idx) & `SRC_EDGE_LATCH;
          end
        end
      end
      ST_HALT, ST_AHALT: begin
        if (wake_now) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RST_DLY;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      state             <= ST_RST_DLY;
      dly_cnt           <= 13'h0000;
      mask              <= `CC_LEVEL3;
      pend              <= 14'h0000;
      trap_pend         <= 1'b0;
      in_trap           <= 1'b0;
      tli_active        <= 1'b0;
      irq_take          <= 1'b0;
      irq_vector        <= 16'h0000;
      push_bytes        <= `STACK_NONE;
      mask_level_high   <= 1'b1;
      mask_level_low    <= 1'b1;
      cpu_hold          <= 1'b1;
      cpu_halted        <= 1'b0;
      active_halt       <= 1'b0;
      periph_clk_en     <= 1'b1;
      osc_run           <= 1'b1;
      time_base_run     <= 1'b1;
      wdg_reset_inhibit <= 1'b0;
    end else if (ce) begin
      state      <= next_state;
      dly_cnt    <= (state == ST_RST_DLY) ? dly_cnt + 13'h0001 : 13'h0000;
      mask       <= next_mask;
      // new events win over a same-cycle clear
      pend       <= (pend & ~(next_clr | periph_clr)) | edge_set
                    | set_now;
      trap_pend  <= trap_exec | (trap_pend & (next_kind != TK_TRAP));
      if (next_kind == TK_TRAP) begin
        in_trap <= 1'b1;
      end else if (cc_pop && !tli_active) begin
        in_trap <= 1'b0;
      end
      if (next_kind == TK_SRC && next_clr == 14'h0001) begin
        tli_active <= 1'b1;
      end else if (cc_pop) begin
        tli_active <= 1'b0;
      end
      irq_take   <= (next_kind != TK_NONE);
      irq_vector <= next_vec;
      push_bytes <= (next_kind == TK_TRAP || next_kind == TK_SRC) ?
                    `STACK_IRQ : `STACK_NONE;
      mask_level_high   <= next_mask[1];
      mask_level_low    <= next_mask[0];
      cpu_hold          <= (next_state == ST_RST_DLY);
      cpu_halted        <= (next_state == ST_HALT) ||
                           (next_state == ST_AHALT);
      active_halt       <= (next_state == ST_AHALT);
      periph_clk_en     <= (next_state == ST_RUN) ||
                           (next_state == ST_RST_DLY);
      osc_run           <= (next_state != ST_HALT);
      time_base_run     <= (next_state != ST_HALT);
      wdg_reset_inhibit <= ahalt_sel;
    end
  end

  // ----------------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= 8'h00;
      if (rd) begin
        case (addr)
          `A_SWPRIO0:   rdata <= swp0;
          `A_SWPRIO1:   rdata <= swp1;
          `A_SWPRIO2:   rdata <= swp2;
          `A_SWPRIO3:   rdata <= swp3;
          `A_EXT_SENSE: rdata <= ext_irq_sense_ctl;
          `A_EXT_SEL:   rdata <= ext_sel;
          `A_CLK_CTL:   rdata <= clk_ctl;
          `A_STATUS:    rdata <= {2'b00, in_trap, cpu_hold, active_halt,
                                  cpu_halted, mask};
          `A_PEND_LO:   rdata <= req[7:0];
          `A_PEND_HI:   rdata <= {2'b00, req[13:8]};
          default:      rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule // irq_controller_halt_wake

`default_nettype wire

/* File: dv/irq_ctl_monitor.sv */
/* Port checker of irq_controller_halt_wake, bound after the module.
   Assumes one clock, synchronous srst and ce held high. */
`timescale 1ns/1ns
`default_nettype none
`include "irq_ctl_consts.vh"
module irq_ctl_monitor #(
  parameter [12:0] LONG_DLY  = `RST_DLY_LONG,
  parameter [12:0] SHORT_DLY = `RST_DLY_SHORT
) (
  input wire logic        clk,
  input wire logic        ce,
  input wire logic        srst,
  input wire logic        insn_boundary,
  input wire logic        exec_strobe,
  input wire logic [7:0]  exec_opcode,
  input wire logic        long_delay_opt,
  input wire logic        irq_take,
  input wire logic [15:0] irq_vector,
  input wire logic [2:0]  push_bytes,
  input wire logic        mask_level_high,
  input wire logic        mask_level_low,
  input wire logic        cpu_hold,
  input wire logic        cpu_halted,
  input wire logic        active_halt,
  input wire logic        periph_clk_en,
  input wire logic        osc_run,
  input wire logic        time_base_run,
  input wire logic        wdg_reset_inhibit
);
  // ----------
  // helpers
  // ----------
  // saturating, so a long run never wraps into a false match
  logic [13:0] since_rst;
  wire  [1:0]  lvl      = {mask_level_high, mask_level_low};
  wire         rst_take = irq_take && irq_vector == `VEC_RESET;
  always @(posedge clk) begin
    if (srst)
      since_rst <= 14'h0000;
    else if (ce && !since_rst[13])
      since_rst <= since_rst + 14'h0001;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence s_halt_exec;
    ce && exec_strobe && exec_opcode == `HALT_OPCODE && !cpu_halted
      && !cpu_hold;
  endsequence
  // ----------
  // properties
  // ----------
  property p_rst_delay;
    rst_take |-> since_rst == {1'b0, long_delay_opt ? LONG_DLY : SHORT_DLY};
  endproperty
  a_rst_delay: assert property (p_rst_delay)
    else $error("reset vector fetch at wrong delay");
  property p_rst_frame;
    rst_take |-> push_bytes == `STACK_NONE && lvl == `CC_LEVEL3;
  endproperty
  a_rst_frame: assert property (p_rst_frame)
    else $error("reset entry pushes or mask wrong");
  property p_entry_push;
    irq_take && !rst_take |-> push_bytes == `STACK_IRQ;
  endproperty
  a_entry_push: assert property (p_entry_push)
    else $error("interrupt entry push count wrong");
  property p_vec_pair;
    irq_take |-> irq_vector[15:5] == 11'h7FF && !irq_vector[0];
  endproperty
  a_vec_pair: assert property (p_vec_pair)
    else $error("vector outside the table");
  property p_take_cause;
    irq_take && !rst_take |-> $past(insn_boundary);
  endproperty
  a_take_cause: assert property (p_take_cause)
    else $error("entry without instruction boundary");
  property p_nmi_mask;
    irq_take && (irq_vector == `VEC_TRAP || irq_vector == `VEC_SRC0)
      |-> lvl == `CC_LEVEL3;
  endproperty
  a_nmi_mask: assert property (p_nmi_mask)
    else $error("top entry did not raise mask to level 3");
  property p_halt_entry;
    s_halt_exec |=> cpu_halted && lvl == `CC_ACTIVE_HALT;
  endproperty
  a_halt_entry: assert property (p_halt_entry)
    else $error("halt opcode did not halt with open mask");
  property p_halt_mode;
    s_halt_exec |=> active_halt == $past(wdg_reset_inhibit);
  endproperty
  a_halt_mode: assert property (p_halt_mode)
    else $error("wrong halt flavour entered");
  property p_ah_clocks;
    active_halt |-> osc_run && time_base_run && !periph_clk_en;
  endproperty
  a_ah_clocks: assert property (p_ah_clocks)
    else $error("clock gates wrong in active halt");
  property p_halted_quiet;
    cpu_halted |=> !irq_take;
  endproperty
  a_halted_quiet: assert property (p_halted_quiet)
    else $error("vector taken while halted");
endmodule // irq_ctl_monitor
bind irq_controller_halt_wake irq_ctl_monitor #(
  .LONG_DLY(LONG_DLY), .SHORT_DLY(SHORT_DLY)
) u_mon (
  .clk(clk), .ce(ce), .srst(srst), .insn_boundary(insn_boundary),
  .exec_strobe(exec_strobe), .exec_opcode(exec_opcode),
  .long_delay_opt(long_delay_opt), .irq_take(irq_take),
  .irq_vector(irq_vector), .push_bytes(push_bytes),
  .mask_level_high(mask_level_high), .mask_level_low(mask_level_low),
  .cpu_hold(cpu_hold), .cpu_halted(cpu_halted),
  .active_halt(active_halt), .periph_clk_en(periph_clk_en),
  .osc_run(osc_run), .time_base_run(time_base_run),
  .wdg_reset_inhibit(wdg_reset_inhibit)
);
`default_nettype wire

/* File: dv/core_model.sv */
/* Core stand-in: marks instruction boundaries and counts entries.
   Assumes clk is the cpu clock and srst the synchronous reset. */
`timescale 1ns/1ns
`default_nettype none
module core_model (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       irq_take,
  output var  logic       insn_boundary,
  output var  logic [7:0] n_take
);
  // two-cycle instructions: never two boundaries back to back
  always @(posedge clk) begin
    if (srst) begin
      insn_boundary <= 1'b0;
      n_take <= 8'h00;
    end else begin
      insn_boundary <= ~insn_boundary;
      if (irq_take)
        n_take <= n_take + 8'h01;
    end
  end
endmodule // core_model
`default_nettype wire

/* File: dv/irq_controller_halt_wake_tb_top.sv */
/* Testbench of the interrupt controller with halt wake logic.
   Assumes core_model as core and irq_ctl_monitor bound to the design. */
`timescale 1ns/1ns
`default_nettype none
`include "irq_ctl_consts.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  miscompares++; $display("unexpected %s exp %0h got %0h", nm, e, g); \
  end end
module irq_controller_halt_wake_tb_top;
  // short reset delays keep the run brief
  localparam [12:0] LDLY = 13'h0010;
  localparam [12:0] SDLY = 13'h0004;
  logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic        pin = 1'b1, trap = 1'b0, pop = 1'b0, exe = 1'b0;
  logic        opt = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00, ext = 8'hFF, opc = 8'h00;
  logic [1:0]  pmask = 2'h0;
  logic [13:0] flag = 14'h0000, en = 14'h0000, clr = 14'h0000;
  wire  [7:0]  rdata, n_take;
  wire  [15:0] vec;
  wire  [2:0]  pb;
  wire         take, mh, ml, hold, halted, ah, pclk, osc, tbr, inh, bnd;
  int          n_tests = 0, miscompares = 0;
  always #4 clk = ~clk;
  irq_controller_halt_wake #(.LONG_DLY(LDLY), .SHORT_DLY(SDLY)) u_dut (
    .clk(clk), .ce(1'b1), .srst(srst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .top_level_pin_irq(pin),
    .ext_pins(ext), .periph_flag(flag), .periph_en(en),
    .periph_clr(clr), .insn_boundary(bnd), .exec_strobe(exe),
    .exec_opcode(opc), .trap_exec(trap), .cc_pop(pop), .pop_mask(pmask),
    .long_delay_opt(opt), .irq_take(take), .irq_vector(vec),
    .push_bytes(pb), .mask_level_high(mh), .mask_level_low(ml),
    .cpu_hold(hold), .cpu_halted(halted), .active_halt(ah),
    .periph_clk_en(pclk), .osc_run(osc), .time_base_run(tbr),
    .wdg_reset_inhibit(inh));
  core_model u_core (.clk(clk), .srst(srst), .irq_take(take),
    .insn_boundary(bnd), .n_take(n_take));
  // ----------
  // bus and core tasks
  // ----------
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask
  task automatic do_pop(input logic [1:0] m);
    @(posedge clk);
    pop <= 1'b1;
    pmask <= m;
    @(posedge clk);
    pop <= 1'b0;
    #1;
    `CHK("mask", m, {mh, ml})
  endtask
  task automatic wait_take(input logic [15:0] v, input logic [1:0] m);
    for (int i = 0; i < 40 && take !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    `CHK("irq_vector", v, vec)
    `CHK("mask", m, {mh, ml})
    `CHK("push", (v == `VEC_RESET) ? `STACK_NONE : `STACK_IRQ, pb)
  endtask
  task automatic do_halt(input logic a);
    @(posedge clk);
    exe <= 1'b1;
    opc <= `HALT_OPCODE;
    @(posedge clk);
    exe <= 1'b0;
    #1;
    `CHK("cpu_halted", 1'b1, halted)
    `CHK("active_halt", a, ah)
    `CHK("mask", `CC_ACTIVE_HALT, {mh, ml})
    `CHK("wdg_reset_inhibit", a, inh)
  endtask
  // ----------
  // scenarios
  // ----------
  task automatic s_reset(input logic o);
    int n;
    @(posedge clk);
    srst <= 1'b1;
    opt <= o;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("cpu_hold", 1'b1, hold)
    `CHK("cpu_halted", 1'b0, halted)
    for (n = 1; n < 100 && take !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    `CHK("reset delay", o ? LDLY : SDLY, n)
    wait_take(`VEC_RESET, `CC_LEVEL3);
    `CHK("cpu_hold", 1'b0, hold)
  endtask
  task automatic s_regs;
    rd_reg(`A_SWPRIO0, `SWPRIO_RST);
    rd_reg(`A_EXT_SENSE, `EXT_SENSE_RST);
    rd_reg(`A_EXT_SEL, `EXT_SEL_RST);
    rd_reg(`A_CLK_CTL, `CLK_CTL_RST);
    wr_reg(4'hC, 8'h5A);
    rd_reg(4'hC, 8'h00);
    wr_reg(`A_PEND_LO, 8'hFF);
    rd_reg(`A_PEND_LO, 8'h00);
  endtask
  task automatic s_trap;
    @(posedge clk);
    trap <= 1'b1;
    @(posedge clk);
    trap <= 1'b0;
    wait_take(`VEC_TRAP, `CC_LEVEL3);
    rd_reg(`A_STATUS, 8'h23);
    @(posedge clk);
    pin <= 1'b0;
    wait_take(`VEC_SRC0, `CC_LEVEL3);
    @(posedge clk);
    pin <= 1'b1;
  endtask
  task automatic s_ext;
    logic [7:0] k;
    do_pop(2'h2);
    wr_reg(`A_EXT_SENSE, {6'h00, `SENSE_FALL});
    @(posedge clk);
    ext <= 8'hFD;
    wait_take(16'hFFF6, `CC_LEVEL3);
    rd_reg(`A_PEND_LO, 8'h00);
    @(posedge clk);
    ext <= 8'hFF;
    for (int c = 1; c < 4; c++) begin
      wr_reg(`A_EXT_SENSE, {4'h0, c[1:0], 2'h0});
      do_pop(2'h2);
      k = n_take;
      @(posedge clk);
      ext <= 8'hFB;
      repeat (12) @(posedge clk);
      do_pop(2'h2);
      @(posedge clk);
      ext <= 8'hFF;
      repeat (12) @(posedge clk);
      `CHK("edge takes", (c == 3) ? 8'h02 : 8'h01, n_take - k)
    end
  endtask
  task automatic s_prio;
    do_pop(2'h1);
    wr_reg(`A_SWPRIO2, 8'hF1);
    @(posedge clk);
    flag <= 14'h0700;
    en <= 14'h0300;
    wait_take(16'hFFE8, 2'h0);
    rd_reg(`A_PEND_HI, 8'h03);
    @(posedge clk);
    flag <= 14'h0000;
    clr <= 14'h0300;
    @(posedge clk);
    clr <= 14'h0000;
    rd_reg(`A_PEND_HI, 8'h00);
  endtask
  task automatic s_halt;
    @(posedge clk);
    exe <= 1'b1;
    opc <= 8'h8F;
    @(posedge clk);
    exe <= 1'b0;
    #1;
    `CHK("cpu_halted", 1'b0, halted)
    do_halt(1'b0);
    @(posedge clk);
    flag <= 14'h0202;
    en <= 14'h0202;
    repeat (12) @(posedge clk);
    #1;
    `CHK("cpu_halted", 1'b1, halted)
    @(posedge clk);
    flag <= 14'h2202;
    en <= 14'h2202;
    wait_take(16'hFFF8, `CC_LEVEL3);
    wr_reg(`A_CLK_CTL, 8'h01);
    do_halt(1'b1);
    `CHK("clock gates", 3'h6, {osc, tbr, pclk})
    wait_take(16'hFFF8, `CC_LEVEL3);
    @(posedge clk);
    flag <= 14'h0000;
    clr <= 14'h3FFF;
    @(posedge clk);
    clr <= 14'h0000;
    wr_reg(`A_CLK_CTL, 8'h00);
    do_halt(1'b0);
  endtask
  // ----------
  // verdict
  // ----------
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    test_done;
  end
  initial begin
    s_reset(1'b0);
    s_regs;
    s_trap;
    s_ext;
    s_prio;
    s_halt;
    s_reset(1'b1);
    test_done;
  end
endmodule // irq_controller_halt_wake_tb_top
`default_nettype wire
